// ### common/sfcfe_pkg.sv
// Opcodes, frame lengths, status layout and carrier types of the serial flash command front end.
package sfcfe_pkg;

  // ***********************************************************************
  // Opcodes
  // ***********************************************************************
  localparam logic [7:0] OP_WR_EN      = 8'h06;
  localparam logic [7:0] OP_WR_DIS     = 8'h04;
  localparam logic [7:0] OP_ID_LONG    = 8'h9f;
  localparam logic [7:0] OP_ID_SHORT   = 8'h9e;
  localparam logic [7:0] OP_STAT_READ  = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE = 8'h01;
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST_READ  = 8'h0b;
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE = 8'hd8;
  localparam logic [7:0] OP_BULK_ERASE = 8'hc7;
  localparam logic [7:0] OP_SLEEP      = 8'hb9;
  localparam logic [7:0] OP_WAKE       = 8'hab;

  // ***********************************************************************
  // Frame geometry, counted in whole bytes from chip select falling
  // ***********************************************************************
  localparam logic [2:0] BIT_FIRST     = 3'h0;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [8:0] NB_NONE       = 9'h000;
  localparam logic [8:0] NB_OPCODE     = 9'h001;
  localparam logic [8:0] NB_STAT_WRITE = 9'h002;
  localparam logic [8:0] NB_ADDR_LAST  = 9'h003;
  localparam logic [8:0] NB_ADDRESSED  = 9'h004;
  localparam logic [8:0] NB_PROG_MIN   = 9'h005;
  localparam logic [8:0] NB_PROG_MAX   = 9'h104;
  localparam logic [8:0] NB_READ_DATA  = 9'h004;
  localparam logic [8:0] NB_FAST_DATA  = 9'h005;
  localparam logic [8:0] NB_SIG_DATA   = 9'h004;
  localparam logic [8:0] NB_ID_LONG    = 9'h014;
  localparam logic [8:0] NB_ID_SHORT   = 9'h003;
  localparam logic [8:0] NB_SATURATE   = 9'h1ff;

  // ***********************************************************************
  // Array map, identification and status layout
  // ***********************************************************************
  localparam int          ARRAY_MSB    = 21;
  localparam int          SECT_MSB     = 21;
  localparam int          SECT_LSB     = 16;
  localparam logic [21:0] ARRAY_STEP   = 22'h000001;
  localparam logic [7:0]  CUSTOM_LEN   = 8'h10;
  localparam int          ID_BITS      = 160;
  localparam int          ST_BUSY_BIT  = 0;
  localparam int          ST_LATCH_BIT = 1;

  // ***********************************************************************
  // Types
  // ***********************************************************************
  typedef enum logic [1:0] {SF_READY, SF_BUSY, SF_SLEEP} sfcfe_state_t;

  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [8:0]  nbytes;
    logic        aligned;
  } sfcfe_frame_t;

  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [5:0]  sector;
  } sfcfe_cycle_t;

endpackage

// ### design/sfcfe_core.sv
// Serial flash command front end: link shifter, output driver and command executor.
`timescale 1ns/1ps
// Notes on behaviour
// - Opcodes, addresses and data move most significant bit first both ways.
// - First rising serial clock after select samples input; each later rise latches a bit.
// - Transaction starts with opcode; addressed commands take three bytes, status write one.
// - Data returning commands end wherever chip select rises during output.
// - Modifying commands and latch commands execute only when ended on a byte boundary.
// - Array accesses are ignored while an internal cycle runs; the cycle continues.
// - 03h reads with three address bytes; 0Bh adds one dummy byte.
// - 02h programs 1 to 256 bytes; D8h erases a sector; C7h erases all.
// - B9h enters power-down; ABh releases, and after three dummies repeats the signature.
// - Opcode 06h alone sets the write latch.
// - Opcode 04h alone clears the write latch.
// - Write latch clears at reset and when any modifying cycle or disable completes.
// - 9Fh returns up to 20 identity bytes, 9Eh up to 3, no preamble.
// - Identity is three bytes, length byte, sixteen custom bytes, driven on falling edges.
// - Custom identity bytes are read-only and zero unless factory loaded.
// - Identity read is not decoded during program or erase and leaves it alone.
// - Chip select rising during identity output ends it and returns to standby.
// - Status read is accepted anytime, including busy, and repeats while clocks run.
// - Array is 64 sectors of 64 KB; sector n starts at n times 10000h.
// - With the write latch clear, status write, program and erase are refused.
// - Busy flag is one during an internal cycle and zero after it.
module sfcfe_core
  import sfcfe_pkg::*;
#(
  parameter logic [7:0]   ID_MAKER       = 8'h5a,   // Arbitrary value.
  parameter logic [7:0]   ID_TYPE        = 8'h3c,   // Arbitrary value.
  parameter logic [7:0]   ID_SIZE        = 8'h47,   // Arbitrary value.
  parameter logic [7:0]   ID_SIGNATURE   = 8'h6e,   // Arbitrary value.
  parameter logic [127:0] FACTORY_CUSTOM = 128'h0   // Factory custom bytes.
)
(
  input  wire logic                  clk,              // System clock.
  input  wire logic                  rst_b,            // Asynchronous reset.
  input  wire logic                  sclk,             // Serial clock from the host.
  input  wire logic                  chip_sel_b,       // Chip select.
  input  wire logic                  serial_in,        // Serial data in.
  output      logic                  serial_out,       // Serial data out.
  output      logic                  serial_out_oe,    // Output enable of serial_out.
  output      logic [23:0]           array_rd_addr,    // Array read address.
  input  wire logic [7:0]            array_rd_data,    // Array read data.
  output      logic                  cyc_start,        // Internal cycle start pulse.
  output      sfcfe_pkg::sfcfe_cycle_t cyc_cmd,        // Internal cycle command.
  input  wire logic                  cyc_done,         // Internal cycle finished pulse.
  output      logic                  busy_flag,        // Internal cycle running.
  output      logic                  write_latch_flag, // Write latch state.
  output      logic                  power_down        // Deep power-down state.
);
  import sfcfe_pkg::*;

  // ***********************************************************************
  // Helper functions
  // ***********************************************************************
  function automatic logic is_op(input logic [7:0] op, input logic [7:0] code);
    is_op = (op == code);
  endfunction

  function automatic logic [7:0] id_byte(input logic [8:0] idx);
    logic [ID_BITS-1:0] id_vec;
    id_vec  = {ID_MAKER, ID_TYPE, ID_SIZE, CUSTOM_LEN, FACTORY_CUSTOM};
    id_byte = id_vec[ID_BITS - 1 - 8 * int'(idx) -: 8];
  endfunction

  // ***********************************************************************
  // Link side: bit and byte counters
  // ***********************************************************************
  logic         link_clr;
  logic [2:0]   bit_idx_reg;
  logic [2:0]   bit_idx_next;
  logic [8:0]   byte_cnt_reg;
  logic [8:0]   byte_cnt_next;

  // Deselection clears the interface as a level, so no edge is needed after a frame.
  assign link_clr = chip_sel_b | ~rst_b;

  always_comb
  begin
    bit_idx_next  = bit_idx_reg + 3'h1;
    byte_cnt_next = byte_cnt_reg;
    if (bit_idx_reg == BIT_LAST && byte_cnt_reg != NB_SATURATE)
    begin
      byte_cnt_next = byte_cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      bit_idx_reg  <= BIT_FIRST;
      byte_cnt_reg <= NB_NONE;
    end
    else
    begin
      bit_idx_reg  <= bit_idx_next;
      byte_cnt_reg <= byte_cnt_next;
    end
  end

  // ***********************************************************************
  // Link side: frame record, held stable after chip select rises
  // ***********************************************************************
  sfcfe_frame_t frame_reg;
  sfcfe_frame_t frame_next;
  logic [8:0]   read_start;
  logic         frame_tog_reg;
  logic         frame_tog_next;

  always_comb
  begin
    read_start = is_op(frame_reg.op, OP_FAST_READ) ? NB_FAST_DATA : NB_READ_DATA;
  end

  always_comb
  begin
    frame_next         = frame_reg;
    frame_next.aligned = (bit_idx_next == BIT_FIRST);
    frame_next.nbytes  = byte_cnt_next;
    // Toggles once per frame that carries at least one serial clock.
    frame_tog_next     = frame_tog_reg;
    if (byte_cnt_reg == NB_NONE && bit_idx_reg == BIT_FIRST)
    begin
      frame_tog_next = ~frame_tog_reg;
    end
    if (byte_cnt_reg == NB_NONE)
    begin
      // opcode shifts in most significant bit first
      frame_next.op = {frame_reg.op[6:0], serial_in};
    end
    else if (byte_cnt_reg <= NB_ADDR_LAST)
    begin
      // address bytes, or the status write data byte
      frame_next.addr = {frame_reg.addr[22:0], serial_in};
    end
    else if ((is_op(frame_reg.op, OP_READ) || is_op(frame_reg.op, OP_FAST_READ))
             && bit_idx_reg == BIT_LAST && byte_cnt_reg >= read_start)
    begin
      // address advances after each data byte and wraps inside the array
      frame_next.addr[ARRAY_MSB:0] = frame_reg.addr[ARRAY_MSB:0] + ARRAY_STEP;
    end
  end

  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frame_reg     <= '0;
      frame_tog_reg <= 1'b0;
    end
    else
    begin
      frame_reg     <= frame_next;
      frame_tog_reg <= frame_tog_next;
    end
  end

  assign array_rd_addr = frame_reg.addr;

  // ***********************************************************************
  // Link side: state flags brought over from the system clock
  // ***********************************************************************
  logic [2:0] lsync1_reg;
  logic [2:0] lsync1_next;
  logic [2:0] lsync2_reg;
  logic [2:0] lsync2_next;
  logic       busy_l;
  logic       latch_l;
  logic       sleep_l;

  always_comb
  begin
    lsync1_next = {busy_flag, write_latch_flag, power_down};
    lsync2_next = lsync1_reg;
  end

  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lsync1_reg <= 3'h0;
      lsync2_reg <= 3'h0;
    end
    else
    begin
      lsync1_reg <= lsync1_next;
      lsync2_reg <= lsync2_next;
    end
  end

  assign busy_l  = lsync2_reg[2];
  assign latch_l = lsync2_reg[1];
  assign sleep_l = lsync2_reg[0];

  // ***********************************************************************
  // Link side: output byte selection and falling edge driver
  // ***********************************************************************
  logic       tx_valid;
  logic [7:0] tx_byte;
  logic [7:0] status_byte;
  logic       tx_bit_reg;
  logic       tx_bit_next;
  logic       tx_oe_reg;
  logic       tx_oe_next;

  always_comb
  begin
    status_byte               = 8'h00;
    status_byte[ST_BUSY_BIT]  = busy_l;
    status_byte[ST_LATCH_BIT] = latch_l;
    tx_valid                  = 1'b0;
    tx_byte                   = 8'h00;
    if (byte_cnt_reg >= NB_OPCODE)
    begin
      unique case (frame_reg.op)
        OP_STAT_READ:
        begin
          tx_valid = 1'b1;
          tx_byte  = status_byte;
        end
        OP_READ, OP_FAST_READ:
        begin
          tx_valid = !busy_l && !sleep_l && byte_cnt_reg >= read_start;
          tx_byte  = array_rd_data;
        end
        OP_ID_LONG, OP_ID_SHORT:
        begin
          tx_valid = !busy_l && !sleep_l && byte_cnt_reg <=
                     (is_op(frame_reg.op, OP_ID_LONG) ? NB_ID_LONG : NB_ID_SHORT);
          // custom bytes come from a constant
          tx_byte  = id_byte(byte_cnt_reg - NB_OPCODE);
        end
        OP_WAKE:
        begin
          tx_valid = byte_cnt_reg >= NB_SIG_DATA;
          tx_byte  = ID_SIGNATURE;
        end
        default:
        begin
          tx_valid = 1'b0;
          tx_byte  = 8'h00;
        end
      endcase
    end
  end

  always_comb
  begin
    tx_bit_next = tx_byte[BIT_LAST - bit_idx_reg];
    tx_oe_next  = tx_valid;
  end

  always_ff @(negedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      tx_bit_reg <= 1'b0;
      tx_oe_reg  <= 1'b0;
    end
    else
    begin
      tx_bit_reg <= tx_bit_next;
      tx_oe_reg  <= tx_oe_next;
    end
  end

  // deselection releases the output at once
  // identity output ends with the frame
  assign serial_out    = tx_bit_reg & tx_oe_reg & ~chip_sel_b;
  assign serial_out_oe = tx_oe_reg & ~chip_sel_b;

  // ***********************************************************************
  // System side: end of frame detection
  // ***********************************************************************
  logic [2:0] cs_sync_reg;
  logic [2:0] cs_sync_next;
  logic [1:0] tog_sync_reg;
  logic [1:0] tog_sync_next;
  logic       tog_seen_reg;
  logic       tog_seen_next;
  logic       cs_rise;
  logic       frame_end;

  always_comb
  begin
    cs_sync_next  = {cs_sync_reg[1], cs_sync_reg[0], chip_sel_b};
    tog_sync_next = {tog_sync_reg[0], frame_tog_reg};
    tog_seen_next = frame_end ? tog_sync_reg[1] : tog_seen_reg;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cs_sync_reg  <= 3'h7;
      tog_sync_reg <= 2'h0;
      tog_seen_reg <= 1'b0;
    end
    else
    begin
      cs_sync_reg  <= cs_sync_next;
      tog_sync_reg <= tog_sync_next;
      tog_seen_reg <= tog_seen_next;
    end
  end

  // The frame record is static here: the host gives no serial clock while deselected.
  // A select pulse without serial clocks leaves the old record; the toggle stops it running twice.
  assign cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign frame_end = cs_rise & (tog_sync_reg[1] != tog_seen_reg);

  // ***********************************************************************
  // System side: command execution
  // ***********************************************************************
  sfcfe_state_t state_reg;
  sfcfe_state_t state_next;
  logic         latch_reg;
  logic         latch_next;
  logic         start_reg;
  logic         start_next;
  sfcfe_cycle_t cmd_reg;
  sfcfe_cycle_t cmd_next;
  logic         whole;
  logic         modify_len;
  logic         modify_hit;
  logic         set_hit;
  logic         clr_hit;
  logic         sleep_hit;
  logic         wake_hit;

  always_comb
  begin
    whole = frame_end && frame_reg.aligned;
    // program length 1 to 256 bytes
    unique case (frame_reg.op)
      OP_STAT_WRITE: modify_len = frame_reg.nbytes == NB_STAT_WRITE;
      OP_PAGE_PROG:  modify_len = frame_reg.nbytes >= NB_PROG_MIN && frame_reg.nbytes <= NB_PROG_MAX;
      OP_SECT_ERASE: modify_len = frame_reg.nbytes == NB_ADDRESSED;
      OP_BULK_ERASE: modify_len = frame_reg.nbytes == NB_OPCODE;
      default:       modify_len = 1'b0;
    endcase
    modify_hit = whole && modify_len && latch_reg;
    set_hit    = whole && is_op(frame_reg.op, OP_WR_EN) && frame_reg.nbytes == NB_OPCODE
                 && state_reg != SF_SLEEP;
    clr_hit    = whole && is_op(frame_reg.op, OP_WR_DIS) && frame_reg.nbytes == NB_OPCODE
                 && state_reg != SF_SLEEP;
    sleep_hit  = whole && is_op(frame_reg.op, OP_SLEEP) && frame_reg.nbytes == NB_OPCODE;
    wake_hit   = frame_end && is_op(frame_reg.op, OP_WAKE) && frame_reg.nbytes >= NB_OPCODE;
  end

  always_comb
  begin
    state_next = state_reg;
    latch_next = latch_reg;
    start_next = 1'b0;
    cmd_next   = cmd_reg;
    unique case (state_reg)
      SF_READY:
      begin
        if (modify_hit)
        begin
          state_next     = SF_BUSY;
          start_next     = 1'b1;
          cmd_next.op    = frame_reg.op;
          cmd_next.addr  = frame_reg.addr;
          cmd_next.sector = frame_reg.addr[SECT_MSB:SECT_LSB];
        end
        else if (sleep_hit)
        begin
          state_next = SF_SLEEP;
        end
      end
      SF_BUSY:
      begin
        // new commands cannot disturb the running cycle
        if (cyc_done)
        begin
          state_next = SF_READY;
          latch_next = 1'b0;
        end
      end
      SF_SLEEP:
      begin
        if (wake_hit)
        begin
          state_next = SF_READY;
        end
      end
      default:
      begin
        state_next = SF_READY;
      end
    endcase
    if (clr_hit)
    begin
      latch_next = 1'b0;
    end
    // A write enable landing with a clear wins.
    if (set_hit)
    begin
      latch_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= SF_READY;
      latch_reg <= 1'b0;
      start_reg <= 1'b0;
      cmd_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      latch_reg <= latch_next;
      start_reg <= start_next;
      cmd_reg   <= cmd_next;
    end
  end

  assign cyc_start        = start_reg;
  assign cyc_cmd          = cmd_reg;
  assign busy_flag        = state_reg == SF_BUSY;
  assign write_latch_flag = latch_reg;
  assign power_down       = state_reg == SF_SLEEP;

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  a_latch_set: assert property (@(posedge clk) disable iff (!rst_b)
    set_hit |=> write_latch_flag)
    else $error("Write enable did not set the latch.");

  a_latch_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (clr_hit && !set_hit) |=> !write_latch_flag)
    else $error("Write disable did not clear the latch.");

  a_done_clears: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_flag && cyc_done && !set_hit) |=> !write_latch_flag && !busy_flag)
    else $error("Cycle completion left latch or busy set.");

  a_start_latch: assert property (@(posedge clk) disable iff (!rst_b)
    cyc_start |-> $past(write_latch_flag) && busy_flag)
    else $error("Cycle started without the write latch.");

  a_start_whole: assert property (@(posedge clk) disable iff (!rst_b)
    cyc_start |-> $past(frame_reg.aligned) && $past(frame_end))
    else $error("Cycle started from a frame off a byte boundary.");

  a_busy_holds: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_flag && !cyc_done) |=> busy_flag && !cyc_start)
    else $error("Busy cycle disturbed before completion.");

  a_sector_map: assert property (@(posedge clk) disable iff (!rst_b)
    cyc_start |-> cyc_cmd.sector == cyc_cmd.addr[SECT_MSB:SECT_LSB])
    else $error("Sector index does not match the address.");

  a_opcode_msb: assert property (@(posedge sclk) disable iff (link_clr)
    (byte_cnt_reg == NB_NONE && bit_idx_reg == BIT_LAST) |=> frame_reg.op[7] == $past(serial_in, 8))
    else $error("Opcode not taken most significant bit first.");

  a_read_busy: assert property (@(posedge sclk) disable iff (link_clr)
    (busy_l && is_op(frame_reg.op, OP_READ) && byte_cnt_reg >= NB_OPCODE) |-> !serial_out_oe)
    else $error("Array read answered during an internal cycle.");

  a_stat_any: assert property (@(posedge sclk) disable iff (link_clr)
    (is_op(frame_reg.op, OP_STAT_READ) && byte_cnt_reg >= NB_OPCODE) |-> serial_out_oe)
    else $error("Status read not answered.");

endmodule

// ### bench/sfcfe_host_model.sv
// Behavioural SPI host that frames bytes into the command front end.
`timescale 1ns/1ps
module sfcfe_host_model
(
  output logic      sclk,       // Serial clock, still between frames.
  output logic      chip_sel_b, // Chip select.
  output logic      serial_in,  // Data to the device.
  input  wire logic serial_out  // Data from the device.
);
  logic [7:0] tx [0:23];
  logic [7:0] rx [0:23];

  initial
  begin
    sclk = 1'b0;
    chip_sel_b = 1'b1;
    serial_in = 1'b0;
    for (int j = 0; j < 24; j++) tx[j] = 8'h00;
  end

  // bytes MSB first, trailing bits only on request.
  task automatic frame(input int nbytes, input int extra);
    int k;
    #7.3 chip_sel_b = 1'b0;
    for (k = 0; k < nbytes * 8 + extra; k++)
    begin
      serial_in = tx[k / 8][7 - k % 8];
      #32 sclk = 1'b1;
      rx[k / 8][7 - k % 8] = serial_out;
      #32 sclk = 1'b0;
    end
    #32 chip_sel_b = 1'b1;
    serial_in = ~serial_in;
    #40;
  endtask
endmodule

// ### bench/serial_flash_command_front_end_bench.sv
// Self-checking bench of the serial flash command front end.
`timescale 1ns/1ps
module serial_flash_command_front_end_bench
  import sfcfe_pkg::*;
;
  logic         clk, rst_b, sclk, chip_sel_b, serial_in, serial_out, serial_out_oe;
  logic         cyc_start, cyc_done, busy_flag, write_latch_flag, power_down, oe_seen;
  logic [23:0]  array_rd_addr;
  logic [23:0]  a;
  logic [7:0]   array_rd_data;
  logic [7:0]   op;
  logic [7:0]   flags;
  logic [31:0]  seed = 32'h858142c6;
  sfcfe_cycle_t cyc_cmd;
  int           bad_count = 0;
  int           check_count = 0;
  int           starts = 0;
  int           n0, k, i;

  function automatic logic [7:0] rdf(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [7:0] idb(input int x);
    return x == 0 ? 8'h91 : x == 1 ? 8'h2b : x == 2 ? 8'h7d : x == 3 ? 8'h10 : 8'h00;
  endfunction
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  assign array_rd_data = rdf(array_rd_addr);
  assign flags = {5'h00, power_down, busy_flag, write_latch_flag};
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (cyc_start === 1'b1) starts++;
  always @(posedge sclk) if (serial_out_oe === 1'b1) oe_seen = 1'b1;

  // Identity and signature values are arbitrary.
  sfcfe_core #(.ID_MAKER(8'h91), .ID_TYPE(8'h2b), .ID_SIZE(8'h7d), .ID_SIGNATURE(8'he4)) uut
  (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .chip_sel_b(chip_sel_b), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .array_rd_addr(array_rd_addr),
    .array_rd_data(array_rd_data), .cyc_start(cyc_start), .cyc_cmd(cyc_cmd), .cyc_done(cyc_done),
    .busy_flag(busy_flag), .write_latch_flag(write_latch_flag), .power_down(power_down)
  );
  sfcfe_host_model host (.sclk(sclk), .chip_sel_b(chip_sel_b), .serial_in(serial_in), .serial_out(serial_out));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input int n, input int extra, input logic [7:0] b0, input logic [7:0] b1 = 8'h00,
                      input logic [7:0] b2 = 8'h00, input logic [7:0] b3 = 8'h00);
    host.tx[0] = b0;
    host.tx[1] = b1;
    host.tx[2] = b2;
    host.tx[3] = b3;
    oe_seen = 1'b0;
    host.frame(n, extra);
    repeat (8) @(posedge clk);
  endtask
  task automatic final_report();
    $display("Checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ***********************************************************************
  // Stimulus and checks
  // ***********************************************************************
  initial
  begin
    rst_b = 1'b0;
    cyc_done = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk(flags, 8'h00);
    send(1, 1, OP_WR_EN, 8'hff);
    chk(flags, 8'h00);
    send(1, 0, OP_WR_EN);
    chk(flags, 8'h01);
    send(1, 0, OP_WR_DIS);
    chk(flags, 8'h00);
    host.tx[4] = 8'h5a;
    send(5, 0, OP_PAGE_PROG, 8'h01, 8'h02, 8'h03);
    chk(8'(starts), 8'h00);
    for (k = 0; k < 4; k++)
    begin
      a = (k == 0) ? 24'h3fffff : 24'(xs()) & 24'h3fffff;
      op = k == 0 ? OP_PAGE_PROG : k == 1 ? OP_SECT_ERASE : k == 2 ? OP_BULK_ERASE : OP_STAT_WRITE;
      send(1, 0, OP_WR_EN);
      n0 = starts;
      host.tx[4] = a[7:0] ^ 8'hff;
      if (k < 2) send(k == 0 ? 5 : 4, 0, op, a[23:16], a[15:8], a[7:0]);
      else send(k == 2 ? 1 : 2, 0, op, a[7:0]);
      chk(8'(starts - n0), 8'h01);
      chk(cyc_cmd.op, op);
      if (k < 2) chk({2'b00, cyc_cmd.sector}, {2'b00, a[21:16]});
      if (k != 2) chk(cyc_cmd.addr[7:0], a[7:0]);
      chk(flags, 8'h03);
      send(2, 0, OP_STAT_READ);
      chk(host.rx[1], 8'h03);
      send(6, 0, OP_READ, a[23:16], a[15:8], a[7:0]);
      chk({7'h00, oe_seen}, 8'h00);
      send(4, 0, OP_ID_LONG);
      chk({7'h00, oe_seen}, 8'h00);
      if (k == 3) send(1, 0, OP_SLEEP);
      cyc_done <= 1'b1;
      @(posedge clk) cyc_done <= 1'b0;
      repeat (4) @(posedge clk);
      if (k == 3) send(0, 0, 8'h00);
      chk(flags, 8'h00);
    end
    for (k = 0; k < 2; k++)
    begin
      a = 24'(xs()) & 24'h3ffff0;
      send(k + 7, 0, k ? OP_FAST_READ : OP_READ, a[23:16], a[15:8], a[7:0]);
      for (i = 0; i < 3; i++) chk(host.rx[k + 4 + i], rdf(a + 24'(i)));
    end
    for (k = 0; k < 2; k++)
    begin
      send(k ? 5 : 22, 0, k ? OP_ID_SHORT : OP_ID_LONG);
      for (i = 0; i < (k ? 4 : 21); i++) chk(host.rx[i + 1], i < (k ? 3 : 20) ? idb(i) : 8'h00);
    end
    send(1, 0, OP_WR_EN);
    send(2, 4, OP_ID_LONG);
    send(2, 0, OP_STAT_READ);
    chk(host.rx[1], 8'h02);
    send(1, 0, OP_SLEEP);
    chk(flags, 8'h05);
    send(6, 0, OP_WAKE);
    chk(host.rx[4], 8'he4);
    chk(host.rx[5], 8'he4);
    chk(flags, 8'h01);
    send(1, 0, OP_WR_DIS);
    send(2, 0, 8'hff, OP_WR_EN);
    chk(flags, 8'h00);
    final_report();
  end

  initial
  begin
    #400000;
    bad_count++;
    final_report();
  end
endmodule
